// file: core/qrwpp_core.sv
/*
 * qrwpp_core: serial command handling for quad word reads, octal word
 * reads, burst wrap setting, status read and single-lane page program.
 * Assumes SCLK, CS_N and IO lines are asynchronous pins (mode 0, SCLK
 * far slower than CORE_CLK), a byte memory answering RD_ADDR on RD_DATA
 * within a few core cycles, and a program sink on PROG_*.
 */
`timescale 1ns/100ps
module qrwpp_core #(
  parameter int PROG_CYCLES = qrwpp_pkg::PROG_CYCLES_DEF
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE_N,
  input wire logic QUAD_EN,
  input wire logic PROT_EN,
  input wire logic [15:0] PROT_FIRST,
  input wire logic [15:0] PROT_LAST,
  output logic [23:0] RD_ADDR,
  input wire logic [7:0] RD_DATA,
  output logic PROG_VALID,
  input wire logic PROG_READY,
  output logic [23:0] PROG_ADDR,
  output logic [7:0] PROG_DATA,
  output logic BUSY,
  output logic WRITE_ENABLE_LATCH,
  output logic CONT_READ,
  output logic [2:0] WRAP_SET
);
  import qrwpp_pkg::*;

  logic [2:0] sclk_s;
  logic [2:0] cs_s;
  logic [3:0] io_s1;
  logic [3:0] io_s2;
  qrwpp_state_t state_q;
  logic [5:0] cnt_q;
  logic [31:0] sh_q;
  logic [31:0] sh_d;
  logic lane4_q;
  logic [7:0] cmd_q;
  logic [7:0] cont_cmd_q;
  logic cont_q;
  logic [2:0] wrap_q;
  logic wel_q;
  logic busy_q;
  logic busy_d;
  logic half_q;
  logic [2:0] sidx_q;
  logic [23:0] rd_addr_q;
  logic [3:0] io_out_q;
  logic [3:0] io_oe_n_q;
  logic [7:0] off_q;
  logic [15:0] page_q;
  logic nb_q;
  logic ovf_q;
  logic [31:0] timer_q;
  logic pend_q;
  logic walk_q;
  logic [8:0] idx_q;
  logic pv_q;
  logic [23:0] pa_q;
  logic [7:0] pd_q;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pmark_q;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic done;
  logic [23:0] addr_c;
  logic [7:0] stat_c;
  logic push_v;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [15:0] f_out_data;
  logic commit;
  logic prog_end;

  // serial clocks in the current phase
  function automatic logic [5:0] phase_len(qrwpp_state_t s, logic l4);
    unique case (s)
      ST_ADDR: phase_len = l4 ? N_QADDR : N_SADDR;
      ST_MODE: phase_len = N_MODE;
      ST_DUMMY: phase_len = N_WORD_DUMMY;
      ST_WRAP: phase_len = N_WRAP;
      default: phase_len = N_BYTE;
    endcase
  endfunction

  // next read address, looping inside the wrap section when enabled
  function automatic logic [23:0] nxt_addr(logic [23:0] a, logic wrap, logic [1:0] len);
    logic [23:0] m;
    logic [23:0] inc;
    m = (WRAP_MIN_BYTES << len) - 24'h000001;
    inc = a + 24'h000001;
    nxt_addr = wrap ? ((a & ~m) | (inc & m)) : inc;
  endfunction

  // page falls inside the protected range
  function automatic logic in_prot(logic [15:0] pg, logic en, logic [15:0] lo, logic [15:0] hi);
    in_prot = en & (pg >= lo) & (pg <= hi);
  endfunction

  // pin synchronisers, third stage only for edge finding
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], SCLK};
      cs_s <= {cs_s[1:0], CS_N};
      io_s1 <= IO_IN;
      io_s2 <= io_s1;
    end
  end

  // edge events and decoded values
  assign rise = sclk_s[1] & ~sclk_s[2] & ~cs_s[1];
  assign fall = ~sclk_s[1] & sclk_s[2] & ~cs_s[1];
  assign cs_fall = ~cs_s[1] & cs_s[2];
  assign cs_rise = cs_s[1] & ~cs_s[2];
  assign sh_d = lane4_q ? {sh_q[27:0], io_s2} : {sh_q[30:0], io_s2[0]};
  assign done = rise & (cnt_q == phase_len(state_q, lane4_q) - 6'd1);
  assign stat_c = {6'h00, wel_q, busy_q};

  // address as taken, low bits forced for word and octal reads
  always_comb begin
    addr_c = sh_d[23:0];
    if (cmd_q == OP_OCT_RD) begin
      addr_c[3:0] = 4'h0;
    end else if (cmd_q == OP_WORD_RD) begin
      addr_c[0] = 1'b0;
    end
  end

  // command sequencer on serial clock edges
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      cnt_q <= 6'd0;
      sh_q <= 32'h00000000;
      lane4_q <= 1'b0;
      cmd_q <= 8'h00;
    end else if (cs_rise) begin
      state_q <= ST_IDLE;
    end else if (cs_fall) begin
      cnt_q <= 6'd0;
      sh_q <= 32'h00000000;
      if (cont_q && !busy_q) begin
        state_q <= ST_ADDR; // address taken at once
        lane4_q <= 1'b1;
        cmd_q <= cont_cmd_q;
      end else begin
        state_q <= ST_CMD;
        lane4_q <= 1'b0;
      end
    end else if (rise) begin
      sh_q <= sh_d;
      cnt_q <= done ? 6'd0 : cnt_q + 6'd1;
      if (done) begin
        unique case (state_q)
          ST_CMD: begin
            cmd_q <= sh_d[7:0];
            lane4_q <= 1'b1;
            state_q <= ST_IGNORE;
            if ((sh_d[7:0] == OP_WORD_RD || sh_d[7:0] == OP_OCT_RD) && QUAD_EN && !busy_q) begin
              state_q <= ST_ADDR;
            end else if (sh_d[7:0] == OP_SET_WRAP && !busy_q) begin
              state_q <= ST_WRAP;
            end else if (sh_d[7:0] == OP_PROG && wel_q && !busy_q) begin
              state_q <= ST_ADDR;
              lane4_q <= 1'b0;
            end else if (sh_d[7:0] == OP_RD_STAT) begin
              state_q <= ST_STAT; // allowed while busy
            end
          end
          ST_ADDR: state_q <= (cmd_q == OP_PROG) ? ST_PDATA : ST_MODE;
          ST_MODE: state_q <= (cmd_q == OP_OCT_RD) ? ST_RDATA : ST_DUMMY;
          ST_DUMMY: state_q <= ST_RDATA;
          ST_WRAP: state_q <= ST_IGNORE;
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // write enable latch, continuous read state and wrap setting
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wel_q <= 1'b0;
      cont_q <= 1'b0;
      cont_cmd_q <= 8'h00;
      wrap_q <= WRAP_RST;
    end else begin
      if (done && state_q == ST_CMD && sh_d[7:0] == OP_WR_EN && !busy_q) begin
        wel_q <= 1'b1;
      end else if (prog_end) begin
        wel_q <= 1'b0;
      end else if (done && state_q == ST_CMD && sh_d[7:0] == OP_WR_DIS && !busy_q) begin
        wel_q <= 1'b0;
      end
      if (done && state_q == ST_MODE) begin
        // low nibble ignored, kept across deselect
        cont_q <= (sh_d[MODE_PAIR_LSB+:2] == MODE_CONT);
        cont_cmd_q <= cmd_q;
      end
      if (done && state_q == ST_WRAP) begin
        // one register, applied to word reads only; octal reads never wrap
        wrap_q <= sh_d[WRAP_FLD_LSB+:3];
      end
    end
  end

  // read address, data nibbles and status bits onto the IO lines
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rd_addr_q <= 24'h000000;
      io_out_q <= 4'h0;
      io_oe_n_q <= 4'hF;
      half_q <= 1'b0;
      sidx_q <= 3'h0;
    end else if (cs_rise || cs_fall) begin
      io_oe_n_q <= 4'hF;
      half_q <= 1'b0;
      sidx_q <= 3'h0;
    end else if (done && state_q == ST_ADDR) begin
      rd_addr_q <= addr_c;
    end else if (fall && state_q == ST_RDATA) begin
      io_oe_n_q <= 4'h0; // driven from first data fall
      half_q <= ~half_q;
      if (!half_q) begin
        io_out_q <= RD_DATA[7:4];
      end else begin
        io_out_q <= RD_DATA[3:0];
        rd_addr_q <= nxt_addr(rd_addr_q, (cmd_q == OP_WORD_RD) & ~wrap_q[WRAP_DIS_POS],
                              wrap_q[2:1]);
      end
    end else if (fall && state_q == ST_STAT) begin
      io_oe_n_q <= 4'hD;
      io_out_q <= {2'b00, stat_c[3'd7 - sidx_q], 1'b0};
      sidx_q <= sidx_q + 3'h1;
    end
  end

  // data bytes of a program command into the staging FIFO
  assign push_v = done & (state_q == ST_PDATA);
  assign commit = cs_rise & (state_q == ST_PDATA) & (cnt_q == 6'd0) & nb_q & ~ovf_q & wel_q
                  & ~in_prot(page_q, PROT_EN, PROT_FIRST, PROT_LAST);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      off_q <= 8'h00;
      page_q <= 16'h0000;
      nb_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (done && state_q == ST_ADDR && cmd_q == OP_PROG) begin
      off_q <= sh_d[7:0];
      page_q <= sh_d[23:8];
      nb_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (push_v) begin
      off_q <= off_q + 8'h01; // wraps to page start
      nb_q <= 1'b1;
      if (!f_in_ready) begin
        ovf_q <= 1'b1;
      end
    end
  end

  qrwpp_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst(RST),
    .in_valid(push_v),
    .in_ready(f_in_ready),
    .in_data({off_q, sh_d[7:0]}),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // page image; later bytes at the same offset overwrite earlier ones
  assign f_out_ready = ~walk_q;

  always_ff @(posedge CORE_CLK) begin
    if (f_out_valid && f_out_ready) begin
      pbuf[f_out_data[15:8]] <= f_out_data[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pmark_q <= '0;
    end else if (done && state_q == ST_ADDR && cmd_q == OP_PROG) begin
      pmark_q <= '0;
    end else if (f_out_valid && f_out_ready) begin
      pmark_q[f_out_data[15:8]] <= 1'b1;
    end
  end

  // self-timed program cycle and write-back of marked bytes
  assign busy_d = commit | (timer_q != 32'h0) | pend_q | walk_q | pv_q;
  assign prog_end = busy_q & ~busy_d;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      timer_q <= 32'h0;
      pend_q <= 1'b0;
      walk_q <= 1'b0;
      idx_q <= 9'h000;
      pv_q <= 1'b0;
      pa_q <= 24'h000000;
      pd_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      if (commit) begin
        timer_q <= PROG_CYCLES[31:0];
        pend_q <= 1'b1;
      end else if (timer_q != 32'h0) begin
        timer_q <= timer_q - 32'h1;
      end
      if (pend_q && !f_out_valid) begin
        pend_q <= 1'b0;
        walk_q <= 1'b1;
        idx_q <= 9'h000;
      end else if (walk_q) begin
        if (pv_q) begin
          pv_q <= ~PROG_READY;
        end else if (idx_q[8]) begin
          walk_q <= 1'b0;
        end else begin
          pv_q <= pmark_q[idx_q[7:0]];
          pa_q <= {page_q, idx_q[7:0]};
          pd_q <= pbuf[idx_q[7:0]];
          idx_q <= idx_q + 9'h001;
        end
      end
    end
  end

  // top outputs, all from flip-flops
  assign IO_OUT = io_out_q;
  assign IO_OE_N = io_oe_n_q;
  assign RD_ADDR = rd_addr_q;
  assign PROG_VALID = pv_q;
  assign PROG_ADDR = pa_q;
  assign PROG_DATA = pd_q;
  assign BUSY = busy_q;
  assign WRITE_ENABLE_LATCH = wel_q;
  assign CONT_READ = cont_q;
  assign WRAP_SET = wrap_q;
endmodule

// file: core/qrwpp_fifo.sv
/*
 * qrwpp_fifo: synchronous FIFO with valid/ready on both sides.
 * Assumes one clock shared by producer and consumer.
 */
`timescale 1ns/100ps
module qrwpp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // handshakes and flags
  assign in_ready = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_q];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// file: include/qrwpp_pkg.sv
/*
 * qrwpp_pkg: opcodes, phase lengths, field positions, reset values,
 * timing counts and the sequencer state type of the quad read / wrap /
 * page program block. Assumes a 4 ns core clock.
 */
package qrwpp_pkg;

  // command codes
  localparam logic [7:0] OP_WORD_RD = 8'hE7;
  localparam logic [7:0] OP_OCT_RD = 8'hE3;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_RD_STAT = 8'h05;

  // serial clocks per phase
  localparam logic [5:0] N_CMD = 6'd8;
  localparam logic [5:0] N_QADDR = 6'd6;
  localparam logic [5:0] N_SADDR = 6'd24;
  localparam logic [5:0] N_MODE = 6'd2;
  localparam logic [5:0] N_WORD_DUMMY = 6'd2;
  localparam logic [5:0] N_WRAP = 6'd8;
  localparam logic [5:0] N_BYTE = 6'd8;

  // fields
  localparam logic [1:0] MODE_CONT = 2'b10;
  localparam int MODE_PAIR_LSB = 4;
  localparam int WRAP_FLD_LSB = 4;
  localparam int WRAP_DIS_POS = 0;
  localparam logic [2:0] WRAP_RST = 3'b001;
  localparam logic [23:0] WRAP_MIN_BYTES = 24'h000008;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_WEL_POS = 1;

  // timing
  localparam int CLK_NS = 4;
  localparam int T_PROG_NS = 700000;
  localparam int PROG_CYCLES_DEF = (T_PROG_NS + CLK_NS - 1) / CLK_NS;

  // page staging
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 16;
  localparam int PAGE_BYTES = 256;

  typedef enum logic [9:0] {
    ST_IDLE = 10'b0000000001,
    ST_CMD = 10'b0000000010,
    ST_ADDR = 10'b0000000100,
    ST_MODE = 10'b0000001000,
    ST_DUMMY = 10'b0000010000,
    ST_RDATA = 10'b0000100000,
    ST_WRAP = 10'b0001000000,
    ST_PDATA = 10'b0010000000,
    ST_STAT = 10'b0100000000,
    ST_IGNORE = 10'b1000000000
  } qrwpp_state_t;

endpackage

// file: tb/qrwpp_core_assertions.sv
/* qrwpp_core_assertions: port checks on the core.
   assumes one CORE_CLK domain, RST active high. */
`timescale 1ns/100ps
module qrwpp_core_assertions #(
  parameter int PROG_CYCLES = 200
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic [3:0] IO_OE_N,
  input wire logic PROG_VALID,
  input wire logic PROG_READY,
  input wire logic [23:0] PROG_ADDR,
  input wire logic [7:0] PROG_DATA,
  input wire logic BUSY,
  input wire logic WRITE_ENABLE_LATCH,
  input wire logic CONT_READ,
  input wire logic [2:0] WRAP_SET
);
  logic [31:0] busy_q;
  logic [3:0] idle_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // cycles spent busy so far
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) busy_q <= '0;
    else busy_q <= BUSY ? busy_q + 32'h1 : '0;
  end
  // cycles with select high, saturating
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) idle_q <= '0;
    else if (!CS_N) idle_q <= '0;
    else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
  end
  prog_hold_a: assert property (PROG_VALID && !PROG_READY |=> PROG_VALID &&
    $stable(PROG_ADDR) && $stable(PROG_DATA)) else $error("write-back byte dropped");
  prog_busy_a: assert property (PROG_VALID |-> BUSY)
    else $error("write-back outside busy");
  wel_clear_a: assert property ($fell(BUSY) |-> !WRITE_ENABLE_LATCH)
    else $error("latch kept after program");
  busy_len_a: assert property ($fell(BUSY) |-> busy_q >= PROG_CYCLES - 1)
    else $error("program cycle too short");
  busy_cs_a: assert property ($rose(BUSY) |-> CS_N)
    else $error("busy while selected");
  busy_wel_a: assert property ($rose(BUSY) |-> $past(WRITE_ENABLE_LATCH))
    else $error("program without latch");
  oe_idle_a: assert property (idle_q >= 4'h8 |-> IO_OE_N == 4'hF)
    else $error("driving while deselected");
  wrap_hold_a: assert property ($changed(WRAP_SET) |-> !CS_N)
    else $error("wrap setting changed outside frame");
  cont_hold_a: assert property ($changed(CONT_READ) |-> !CS_N)
    else $error("continuous state changed outside frame");
  cover property ($rose(BUSY));
  cover property ($rose(CONT_READ));
  cover property ($fell(WRAP_SET[0]));
  cover property (PROG_VALID && !PROG_READY);
endmodule
bind qrwpp_core qrwpp_core_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .CS_N(CS_N), .IO_OE_N(IO_OE_N),
  .PROG_VALID(PROG_VALID), .PROG_READY(PROG_READY), .PROG_ADDR(PROG_ADDR),
  .PROG_DATA(PROG_DATA), .BUSY(BUSY), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .CONT_READ(CONT_READ),
  .WRAP_SET(WRAP_SET));

// file: tb/qrwpp_core_test.sv
/* qrwpp_core_test: wrap and read rows, then continuous read,
   refusals and page program. assumes host model and byte memory. */
`timescale 1ns/100ps
module qrwpp_core_test;
  import qrwpp_pkg::*;
  localparam int PC = 2000;
  localparam logic [51:0] ROWS [6] = '{
    {4'h0, 8'h8F, OP_WORD_RD, 24'h0012F6, 8'h00},
    {4'h2, 8'h2A, OP_WORD_RD, 24'h003437, 8'h50},
    {4'h4, 8'h40, OP_WORD_RD, 24'h0000BC, 8'hC0},
    {4'h6, 8'h60, OP_WORD_RD, 24'h00567A, 8'hF0},
    {4'h0, 8'h00, OP_OCT_RD, 24'h00567A, 8'h00},
    {4'h1, 8'h10, OP_WORD_RD, 24'h0000FE, 8'h00}};
  localparam logic [31:0] PEXP [3] = '{32'h00120033, 32'h0012FE11, 32'h0012FF22};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, quad_en, prot_en, prog_valid, prog_ready, busy, write_enable_latch, cont_read;
  logic [3:0] host_io, io_in, io_out, io_oe_n;
  logic [23:0] rd_addr, prog_addr;
  logic [7:0] prog_data;
  logic [2:0] wrap_set;
  logic [2:0] ws_exp = 3'h1;
  logic [5:0] tick = 6'h00;
  logic [31:0] wb[$];
  int n_errors = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  assign io_in = (io_out & ~io_oe_n) | (host_io & io_oe_n);
  qrwpp_core #(.PROG_CYCLES(PC)) i_dut (.CORE_CLK(clk), .RST(rst), .SCLK(sclk),
    .CS_N(cs_n), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE_N(io_oe_n), .QUAD_EN(quad_en),
    .PROT_EN(prot_en), .PROT_FIRST(16'h0012), .PROT_LAST(16'h0012), .RD_ADDR(rd_addr),
    .RD_DATA(rd_addr[7:0] ^ 8'hA5), .PROG_VALID(prog_valid), .PROG_READY(prog_ready),
    .PROG_ADDR(prog_addr), .PROG_DATA(prog_data), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch),
    .CONT_READ(cont_read), .WRAP_SET(wrap_set));
  qrwpp_host u_host (.sclk(sclk), .cs_n(cs_n), .io(host_io), .io_out(io_out),
    .oe_n(io_oe_n));
  // sink stalls half the time so write-back bytes are held waiting for ready
  always @(posedge clk) begin
    tick <= tick + 6'h01;
    prog_ready <= tick[5];
    if (prog_valid && prog_ready) wb.push_back({prog_addr, prog_data});
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmd8(input logic [7:0] c);
    u_host.start();
    u_host.shift(c, 8, 1'b0);
    u_host.stop();
  endtask
  task automatic set_wrap(input logic [7:0] w);
    u_host.start();
    u_host.shift(OP_SET_WRAP, 8, 1'b0);
    u_host.shift(32'h0, 6, 1'b1);
    u_host.shift(w, 2, 1'b1);
    u_host.stop();
    ws_exp = w[6:4];
  endtask
  // ten-byte quad read; drv low means the command must be ignored
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
    input bit cmd, input bit drv);
    logic [7:0] ea, sz;
    u_host.got.delete();
    u_host.start();
    if (cmd) u_host.shift(op, 8, 1'b0);
    u_host.shift(a, 6, 1'b1);
    u_host.shift(m, 2, 1'b1);
    if (op == OP_WORD_RD) u_host.shift(32'h0, 2, 1'b1);
    u_host.get(20);
    u_host.stop();
    a[7:0] = op == OP_WORD_RD ? {a[7:1], 1'b0} : {a[7:4], 4'h0};
    sz = 8'h08 << ws_exp[2:1];
    for (int i = 0; i < 10; i++) begin
      ea = a[7:0] + i[7:0];
      if (op == OP_WORD_RD && !ws_exp[0]) ea = (a[7:0] & ~(sz - 8'h01)) | (ea & (sz - 8'h01));
      if (drv) chk({u_host.got[2*i][3:0], u_host.got[2*i+1][3:0]}, ea ^ 8'hA5);
      else chk(u_host.got[2*i][7:4], 4'hF);
    end
  endtask
  task automatic prog(input logic [23:0] a, input int nb);
    u_host.start();
    u_host.shift(OP_PROG, 8, 1'b0);
    u_host.shift(a, 24, 1'b0);
    u_host.shift(32'h112233, nb, 1'b0);
    u_host.stop();
    repeat (50) @(posedge clk);
  endtask
  initial begin
    logic [7:0] st;
    quad_en = 1'b1;
    prot_en = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({io_oe_n, busy, write_enable_latch, cont_read, wrap_set}, {4'hF, 3'h0, 3'h1});
    foreach (ROWS[r]) begin
      set_wrap(ROWS[r][47:40]);
      chk(wrap_set, ROWS[r][50:48]);
      rd(ROWS[r][39:32], ROWS[r][31:8], ROWS[r][7:0], 1'b1, 1'b1);
      chk(cont_read, 1'b0);
    end
    rd(OP_WORD_RD, 24'h000010, 8'h20, 1'b1, 1'b1);
    chk(cont_read, 1'b1);
    rd(OP_WORD_RD, 24'h000020, 8'h00, 1'b0, 1'b1);
    chk(cont_read, 1'b0);
    rd(OP_OCT_RD, 24'h000040, 8'hA0, 1'b1, 1'b1);
    rd(OP_OCT_RD, 24'h000080, 8'h20, 1'b0, 1'b1);
    chk(cont_read, 1'b1);
    cmd8(8'hFF);
    chk(cont_read, 1'b0);
    @(posedge clk);
    quad_en <= 1'b0;
    rd(OP_WORD_RD, 24'h000010, 8'h00, 1'b1, 1'b0);
    rd(OP_OCT_RD, 24'h000010, 8'h00, 1'b1, 1'b0);
    @(posedge clk);
    quad_en <= 1'b1;
    prog(24'h0012FE, 24);
    chk(busy, 1'b0);
    cmd8(OP_WR_EN);
    chk(write_enable_latch, 1'b1);
    cmd8(OP_WR_DIS);
    chk(write_enable_latch, 1'b0);
    cmd8(OP_WR_EN);
    prog(24'h0012FE, 11);
    chk({busy, write_enable_latch}, 2'b01);
    prot_en <= 1'b1;
    prog(24'h0012FE, 24);
    chk(busy, 1'b0);
    prot_en <= 1'b0;
    prog(24'h0012FE, 24);
    chk(busy, 1'b1);
    u_host.got.delete();
    u_host.start();
    u_host.shift(OP_RD_STAT, 8, 1'b0);
    u_host.get(8);
    u_host.stop();
    for (int i = 0; i < 8; i++) st = {st[6:0], u_host.got[i][1]};
    chk(st, 8'h03);
    for (int i = 0; i < 4 * PC && busy !== 1'b0; i++) @(posedge clk);
    chk({busy, write_enable_latch}, 2'b00);
    chk(wb.size(), 3);
    foreach (wb[i]) chk(wb[i], PEXP[i]);
    // wrap and continuous state must not outlive a reset in mid-run
    set_wrap(8'h20);
    rd(OP_WORD_RD, 24'h00003C, 8'h20, 1'b1, 1'b1);
    chk({cont_read, wrap_set}, {1'b1, 3'h2});
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({io_oe_n, busy, write_enable_latch, cont_read, wrap_set}, {4'hF, 3'h0, 3'h1});
    report_and_stop();
  end
  // cut a hang short
  initial begin
    #300000;
    n_errors++;
    report_and_stop();
  end
endmodule

// file: tb/qrwpp_host.sv
/* qrwpp_host: behavioural serial host, mode 0, 125 ns clock.
   assumes the bench calls its tasks. */
`timescale 1ns/100ps
module qrwpp_host (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io,
  input wire logic [3:0] io_out,
  input wire logic [3:0] oe_n
);
  logic [7:0] got[$];
  // idle: deselected, clock low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io = 4'hF;
  end
  // open a frame
  task automatic start();
    cs_n = 1'b0;
    #62.5;
  endtask
  // n bits on io_line_zero or n nibbles on four lines, msb first
  task automatic shift(input logic [31:0] v, input int n, input bit q);
    for (int k = n - 1; k >= 0; k--) begin
      #62.5 sclk = 1'b0;
      io = q ? v[4*k +: 4] : {3'h7, v[k]};
      #62.5 sclk = 1'b1;
    end
  endtask
  // release lines before the launching fall, sample at each rise
  task automatic get(input int n);
    #10 io = ~io;
    for (int k = 0; k < n; k++) begin
      #52.5 sclk = 1'b0;
      #62.5 sclk = 1'b1;
      got.push_back({oe_n, io_out});
      #10 io = ~io;
    end
  endtask
  // close on a whole clock, clock stands low
  task automatic stop();
    #62.5 sclk = 1'b0;
    #62.5 cs_n = 1'b1;
    io = ~io;
    #500;
  endtask
endmodule
